//--- hdl/cell_reg_map.vh
// Register map, field positions and reset values of the logic cell register stage.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef CELL_REG_MAP_VH
`define CELL_REG_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CELL_ADR_CFG 8'h00
`define CELL_ADR_INV 8'h04
`define CELL_ADR_STATUS 8'h08
`define CELL_ADR_FORCE 8'h0C

// ****************************************
// Configuration register fields
// ****************************************
`define CFG_SCHEME_LSB 0
`define CFG_SCHEME_MSB 2
`define CFG_COUNTER_BIT 3
`define CFG_CLKSEL_BIT 4
`define CFG_RESET 5'h00
`define CFG_WIDTH 5

// ****************************************
// Asynchronous control schemes
// ****************************************
`define SCHEME_NONE 3'h0
`define SCHEME_CLEAR 3'h1
`define SCHEME_PRESET_LOAD 3'h2
`define SCHEME_PRESET_INV 3'h3
`define SCHEME_PRESET_CLEAR 3'h4
`define SCHEME_LOAD_CLEAR 3'h5
`define SCHEME_LOAD_PRESET 3'h6
`define SCHEME_LOAD_ONLY 3'h7

// ****************************************
// Inversion register fields
// ****************************************
`define INV_CLK_A_BIT 0
`define INV_CLK_B_BIT 1
`define INV_CTRL_A_BIT 2
`define INV_CTRL_B_BIT 3
`define INV_DATA_A_BIT 4
`define INV_DATA_B_BIT 5
`define INV_DATA_3_BIT 6
`define INV_DATA_4_BIT 7
`define INV_RESET 8'h00
`define INV_WIDTH 8

// ****************************************
// Status register fields
// ****************************************
`define STS_OUT_BIT 0
`define STS_CARRY_BIT 1
`define STS_CLEAR_BIT 2
`define STS_PRESET_BIT 3
`define STS_WIDTH 4

// ****************************************
// Software line force register fields
// ****************************************
`define FRC_CTRL_A_BIT 0
`define FRC_CTRL_B_BIT 1
`define FRC_RESET 2'h0
`define FRC_WIDTH 2

`endif

//--- hdl/cell_flop.v
// Cell flip-flop with clock enable and asynchronous force-to-zero and force-to-one.
// Assumes the two force inputs are never high together; the caller resolves priority.
`timescale 1ns/10ps
module cell_flop (
  input wire sys_clk,
  input wire force_zero,
  input wire force_one,
  input wire clk_en,
  input wire d,
  output reg q
);

  // ****************************************
  // Storage
  // ****************************************
  // RULE17 async beats clock
  always @(posedge sys_clk or posedge force_zero or posedge force_one) begin
    if (force_zero) begin
      q <= 1'b0;
    end else if (force_one) begin
      q <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

endmodule

//--- hdl/logic_cell_register_control.v
// Register stage of one logic cell: counter mode, sync load and async control schemes.
// Assumes all data and control inputs are synchronous to sys_clk; registers via Wishbone.
//
// Operation
// RULE1 - Counter mode offers count enable, clock enable, direction and data load.
// RULE2 - Counter controls come from cell data inputs, carry in and own output.
// RULE3 - Two three-input lookup functions give next count bit and carry out.
// RULE4 - A two-to-one mux picks count value or load data synchronously.
// RULE5 - Register loads asynchronously through clear and preset, no lookup logic.
// RULE6 - Clear-only: either control line clears; preset held inactive.
// RULE7 - Preset as load: third input high, line a forces register to one.
// RULE8 - Preset may be clear with register input and output both inverted.
// RULE9 - Cell inputs have selectable inversion; one-line preset frees third input.
// RULE10 - Preset and clear: line a presets via third input, line b clears.
// RULE11 - Load with clear: line a drives preset and clear, b only clear.
// RULE12 - Load with preset: inverted register, b presets, a loads inverted data.
// RULE13 - Load only: line a loads third input through preset and clear.
// RULE14 - Four shared lines with selectable inversion: two clocks, two clear/preset.
// RULE15 - Flip-flop captures only on edges where clock enable is high.
// RULE16 - Clear and preset together: clear wins, output zero until released; in the load-with-preset scheme cell_out goes to one.
// RULE17 - Async controls act at once; sync operation resumes next clock edge.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "cell_reg_map.vh"
module logic_cell_register_control (
  input wire sys_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire block_clock_line_a,
  input wire block_clock_line_b,
  input wire block_control_line_a,
  input wire block_control_line_b,
  input wire cell_data_a,
  input wire cell_data_b,
  input wire third_cell_input,
  input wire fourth_cell_input,
  input wire cell_clock_enable,
  input wire carry_in,
  output wire cell_out,
  output reg carry_out
);

  // ****************************************
  // Configuration state
  // ****************************************
  reg [`CFG_WIDTH-1:0] cfg_r;
  reg [`INV_WIDTH-1:0] inv_r;
  reg [`FRC_WIDTH-1:0] frc_r;
  wire [2:0] scheme;
  wire counter_mode;
  wire q;

  assign scheme = cfg_r[`CFG_SCHEME_MSB:`CFG_SCHEME_LSB];
  assign counter_mode = cfg_r[`CFG_COUNTER_BIT];

  // ****************************************
  // Lookup functions
  // ****************************************
  // Next count bit from own output and carry; direction input unused
  function count_bit_fn;
    input cur;
    input up;
    input cin;
    begin
      count_bit_fn = cur ^ cin;
    end
  endfunction

  // Fast carry: up ripples on ones, down ripples on zeros
  function carry_fn;
    input cur;
    input up;
    input cin;
    begin
      carry_fn = cin & (up ? cur : ~cur);
    end
  endfunction

  // ****************************************
  // Scheme decode
  // ****************************************
  // Inverted-register schemes keep the logical value and swap clear and preset
  function scheme_inverted;
    input [2:0] s;
    begin
      scheme_inverted = (s == `SCHEME_PRESET_INV) || (s == `SCHEME_LOAD_PRESET);
    end
  endfunction

  // Physical preset request of the flip-flop
  function phys_preset;
    input [2:0] s;
    input a;
    input b;
    input d3;
    begin
      case (s)
        `SCHEME_PRESET_LOAD,
        `SCHEME_PRESET_CLEAR,
        `SCHEME_LOAD_CLEAR,
        `SCHEME_LOAD_PRESET,
        `SCHEME_LOAD_ONLY: begin
          phys_preset = a & d3;
        end
        default: begin
          phys_preset = 1'b0;
        end
      endcase
    end
  endfunction

  // Physical clear request of the flip-flop
  function phys_clear;
    input [2:0] s;
    input a;
    input b;
    input d3;
    begin
      case (s)
        `SCHEME_CLEAR: begin
          phys_clear = a | b;
        end
        `SCHEME_PRESET_INV: begin
          phys_clear = a;
        end
        `SCHEME_PRESET_LOAD,
        `SCHEME_LOAD_ONLY: begin
          phys_clear = a & ~d3;
        end
        `SCHEME_PRESET_CLEAR,
        `SCHEME_LOAD_CLEAR,
        `SCHEME_LOAD_PRESET: begin
          phys_clear = (a & ~d3) | b;
        end
        default: begin
          phys_clear = 1'b0;
        end
      endcase
    end
  endfunction

  // ****************************************
  // Input inversion
  // ****************************************
  // RULE9 selectable input inversion
  wire data_a_x = cell_data_a ^ inv_r[`INV_DATA_A_BIT];
  wire data_b_x = cell_data_b ^ inv_r[`INV_DATA_B_BIT];
  wire data_3_x = third_cell_input ^ inv_r[`INV_DATA_3_BIT];
  wire data_4_x = fourth_cell_input ^ inv_r[`INV_DATA_4_BIT];
  // RULE14 shared lines with inversion
  wire clk_line_a_x = block_clock_line_a ^ inv_r[`INV_CLK_A_BIT];
  wire clk_line_b_x = block_clock_line_b ^ inv_r[`INV_CLK_B_BIT];
  wire ctrl_a_x = (block_control_line_a ^ inv_r[`INV_CTRL_A_BIT]) | frc_r[`FRC_CTRL_A_BIT];
  wire ctrl_b_x = (block_control_line_b ^ inv_r[`INV_CTRL_B_BIT]) | frc_r[`FRC_CTRL_B_BIT];
  // RULE14 selected clock line qualifies sys_clk
  wire clk_line_x = cfg_r[`CFG_CLKSEL_BIT] ? clk_line_b_x : clk_line_a_x;

  // ****************************************
  // Counter datapath
  // ****************************************
  wire inv_mode = scheme_inverted(scheme);
  // Logical value of the cell before any storage inversion
  wire cur_val = q;
  // RULE1 count enable gates carry
  // RULE2 controls from data inputs
  wire count_en = data_a_x;
  wire count_up = data_b_x;
  wire cin_eff = carry_in & count_en;
  // RULE3 count bit and carry lookups
  wire count_next = count_bit_fn(cur_val, count_up, cin_eff);
  wire carry_next = carry_fn(cur_val, count_up, cin_eff);
  // RULE4 sync load mux
  wire count_or_load = data_4_x ? data_3_x : count_next;
  // Normal mode registers the fourth input directly
  wire d_logical = counter_mode ? count_or_load : data_4_x;
  // RULE15 clock enable
  // RULE1 clock enable in counter mode
  wire clk_en = cell_clock_enable & clk_line_x;

  // ****************************************
  // Asynchronous control
  // ****************************************
  // RULE5 load through preset and clear
  // RULE6 clear-only scheme
  // RULE7 preset as load of third input
  // RULE10 preset and clear
  // RULE11 load with clear
  // RULE12 load with preset
  // RULE13 load only
  wire pre_p = phys_preset(scheme, ctrl_a_x, ctrl_b_x, data_3_x);
  wire clr_p = phys_clear(scheme, ctrl_a_x, ctrl_b_x, data_3_x);
  // RULE16 physical clear wins
  wire pre_only = pre_p & ~clr_p;
  // RULE8 inverted storage swaps clear and preset
  wire force_zero = ~rst_n | (inv_mode ? pre_only : clr_p);
  wire force_one = rst_n & (inv_mode ? clr_p : pre_only);

  cell_flop u_flop (
    .sys_clk(sys_clk),
    .force_zero(force_zero),
    .force_one(force_one),
    .clk_en(clk_en),
    .d(d_logical),
    .q(q)
  );

  assign cell_out = q;

  // ****************************************
  // Registered carry out
  // ****************************************
  // RULE3 carry to next cell
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_out <= 1'b0;
    end else begin
      carry_out <= counter_mode & carry_next;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands at the edge where the master samples ack high
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `CELL_ADR_CFG: begin
        rd_nxt[`CFG_WIDTH-1:0] = cfg_r;
      end
      `CELL_ADR_INV: begin
        rd_nxt[`INV_WIDTH-1:0] = inv_r;
      end
      `CELL_ADR_STATUS: begin
        rd_nxt[`STS_OUT_BIT] = q;
        rd_nxt[`STS_CARRY_BIT] = carry_out;
        rd_nxt[`STS_CLEAR_BIT] = force_zero;
        rd_nxt[`STS_PRESET_BIT] = force_one;
      end
      `CELL_ADR_FORCE: begin
        rd_nxt[`FRC_WIDTH-1:0] = frc_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_nxt : 32'h0000_0000;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `CFG_RESET;
      inv_r <= `INV_RESET;
      frc_r <= `FRC_RESET;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `CELL_ADR_CFG: begin
          cfg_r <= wb_dat_i[`CFG_WIDTH-1:0];
        end
        `CELL_ADR_INV: begin
          inv_r <= wb_dat_i[`INV_WIDTH-1:0];
        end
        `CELL_ADR_FORCE: begin
          frc_r <= wb_dat_i[`FRC_WIDTH-1:0];
        end
        default: begin
          frc_r <= frc_r;
        end
      endcase
    end
  end

endmodule

//--- sim/cell_props.sv
// Port-level assertions for the cell register stage.
// Assumes INV is zero whenever a control line is driven high.
`timescale 1ns/10ps
module cell_props (
  input wire sys_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire block_clock_line_a,
  input wire block_clock_line_b,
  input wire block_control_line_a,
  input wire block_control_line_b,
  input wire cell_data_a,
  input wire cell_data_b,
  input wire third_cell_input,
  input wire fourth_cell_input,
  input wire cell_clock_enable,
  input wire carry_in,
  input wire cell_out,
  input wire carry_out
);
  // ****
  // Config shadow
  // ****
  reg [4:0] cfg_r;
  wire [2:0] s = cfg_r[2:0];
  wire ca = block_control_line_a;
  wire cb = block_control_line_b;
  wire d3 = third_cell_input;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      cfg_r <= 5'h00;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
      cfg_r <= wb_dat_i[4:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  chk_clear_only: assert property (s == 3'h1 && (ca || cb) |-> !cell_out)
    else $error("clear-only failed");
  chk_preset_load: assert property ((s == 3'h2 || s == 3'h4) && ca && !cb && d3 |-> cell_out)
    else $error("preset failed");
  chk_clear_line_b: assert property ((s == 3'h4 || s == 3'h5) && cb |-> !cell_out)
    else $error("line b clear failed");
  chk_load_clear: assert property (s == 3'h5 && ca && !cb |-> cell_out == d3)
    else $error("load with clear failed");
  chk_load_preset: assert property (s == 3'h6 && (ca || cb) |-> cell_out == (cb || !d3))
    else $error("load with preset failed");
  chk_load_only: assert property (s == 3'h7 && ca |-> cell_out == d3)
    else $error("load only failed");
  chk_hold_disabled: assert property (s == 3'h0 && !cell_clock_enable ##1 s == 3'h0
    |-> $stable(cell_out))
    else $error("captured without enable");
  chk_sync_load: assert property (cfg_r == 5'h08 && cell_clock_enable && block_clock_line_a
    && fourth_cell_input |=> cell_out == $past(d3))
    else $error("sync load failed");
endmodule
bind logic_cell_register_control cell_props u_props (.*);

//--- sim/cell_far_side.sv
// Far-side model: shared control lines and local routing.
// Assumes callers invoke put once per clock edge.
`timescale 1ns/10ps
module cell_far_side (
  input wire sys_clk,
  output wire block_clock_line_a,
  output wire block_clock_line_b,
  output wire block_control_line_a,
  output wire block_control_line_b,
  output wire cell_data_a,
  output wire cell_data_b,
  output wire third_cell_input,
  output wire fourth_cell_input,
  output wire cell_clock_enable,
  output wire carry_in
);
  reg [9:0] lines_r;
  assign {block_control_line_a, block_control_line_b, third_cell_input, fourth_cell_input,
    cell_data_a, cell_data_b, cell_clock_enable, carry_in, block_clock_line_a,
    block_clock_line_b} = lines_r;
  initial lines_r = 10'h000;
  // Lines change just after an edge
  task put(input [9:0] v);
    begin
      @(posedge sys_clk);
      lines_r <= v;
    end
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the cell register stage.
// Assumes the far-side model and checker are compiled alongside.
`timescale 1ns/10ps
module testbench;
  reg sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  reg [7:0] wb_adr_i;
  reg [3:0] wb_sel_i;
  reg [31:0] wb_dat_i, rdat;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, cell_out, carry_out, block_clock_line_a, block_clock_line_b;
  wire block_control_line_a, block_control_line_b, cell_data_a, cell_data_b;
  wire third_cell_input, fourth_cell_input, cell_clock_enable, carry_in;
  integer num_errors, checked, i;
  reg [7:0] e;
  reg [7:0] tab [0:14] = '{8'h32, 8'h2A, 8'h55, 8'h4B, 8'h71, 8'h95, 8'h8A, 8'h9E,
    8'hB2, 8'hB5, 8'hAA, 8'hC9, 8'hD6, 8'hF5, 8'hF2};
  logic_cell_register_control u_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .block_clock_line_a(block_clock_line_a),
    .block_clock_line_b(block_clock_line_b),
    .block_control_line_a(block_control_line_a),
    .block_control_line_b(block_control_line_b),
    .cell_data_a(cell_data_a),
    .cell_data_b(cell_data_b),
    .third_cell_input(third_cell_input),
    .fourth_cell_input(fourth_cell_input),
    .cell_clock_enable(cell_clock_enable),
    .carry_in(carry_in),
    .cell_out(cell_out),
    .carry_out(carry_out)
  );
  cell_far_side u_far (
    .sys_clk(sys_clk),
    .block_clock_line_a(block_clock_line_a),
    .block_clock_line_b(block_clock_line_b),
    .block_control_line_a(block_control_line_a),
    .block_control_line_b(block_control_line_b),
    .cell_data_a(cell_data_a),
    .cell_data_b(cell_data_b),
    .third_cell_input(third_cell_input),
    .fourth_cell_input(fourth_cell_input),
    .cell_clock_enable(cell_clock_enable),
    .carry_in(carry_in)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****
  // Tasks
  // ****
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== ex) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task co(input string nm, input ex);
    chk(nm, {31'h0, ex}, {31'h0, cell_out});
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] ex, input string nm);
    begin
      wb(1'b0, a, 32'h0);
      chk(nm, ex, rdat);
    end
  endtask
  task pre(input st);
    begin
      u_far.put({3'b000, st, 6'h0E});
      u_far.put(10'h004);
      #1;
      co("preload", st);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #100000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  // ****
  // Tests
  // ****
  initial begin
    num_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
    wb_sel_i = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    wb(1'b1, 8'h00, 32'hFFFFFFFF);
    for (i = 0; i < 5; i = i + 1)
      rd(8'(i * 4), 32'h0, "reset reg");
    wb_sel_i <= 4'h1;
    for (i = 0; i < 4; i = i + 1)
      wb(1'b1, 8'(i * 4), 32'hFFFFFFFF);
    rd(8'h00, 32'h1F, "cfg");
    rd(8'h04, 32'hFF, "inv");
    rd(8'h0C, 32'h3, "force");
    for (i = 0; i < 4; i = i + 1)
      wb(1'b1, 8'(i * 4), 32'h0);
    $display("registers done");
    pre(1'b0);
    wb(1'b1, 8'h00, 32'h08);
    u_far.put(10'h03E);
    @(posedge sys_clk);
    #1;
    co("count up", 1'b1);
    @(posedge sys_clk);
    #1;
    co("count wrap", 1'b0);
    chk("carry", 32'h1, {31'h0, carry_out});
    u_far.put(10'h036);
    repeat (2) @(posedge sys_clk);
    #1;
    co("hold", 1'b1);
    u_far.put(10'h05E);
    @(posedge sys_clk);
    #1;
    co("sync load", 1'b0);
    u_far.put(10'h004);
    u_far.put(10'h02E);
    u_far.put(10'h02A);
    #1;
    co("count down", 1'b1);
    chk("borrow", 32'h1, {31'h0, carry_out});
    u_far.put(10'h004);
    #1;
    co("carry gate", 1'b1);
    chk("borrow drop", 32'h0, {31'h0, carry_out});
    $display("counter done");
    wb(1'b1, 8'h00, 32'h10);
    u_far.put(10'h00E);
    u_far.put(10'h00D);
    #1;
    co("line a ignored", 1'b1);
    u_far.put(10'h004);
    #1;
    co("line b clocks", 1'b0);
    $display("clock line done");
    for (i = 0; i < 15; i = i + 1) begin
      e = tab[i];
      wb(1'b1, 8'h00, 32'h0);
      pre(e[1]);
      wb(1'b1, 8'h00, {29'h0, e[7:5]});
      u_far.put({e[4:2], 7'h04});
      #1;
      co("async", e[0]);
      u_far.put(10'h004);
    end
    $display("async done");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h84);
    u_far.put(10'h00E);
    u_far.put(10'h004);
    #1;
    co("inv data", 1'b1);
    wb(1'b1, 8'h00, 32'h1);
    co("inv line", 1'b0);
    rd(8'h08, 32'h4, "status");
    $display("inversion done");
    tally_and_finish;
  end
endmodule
